// ### inc/cal_gate_regs.vh
// Constants for the calibration mode command gate
`ifndef CAL_GATE_REGS_VH
`define CAL_GATE_REGS_VH

// Decoded command codes
`define OP_OTHER      3'h0
`define OP_ENTER_CAL  3'h1
`define OP_END_CAL    3'h2
`define OP_CHG_KEY    3'h3
`define OP_CJ_CAL     3'h4
`define OP_STAT_QRY   3'h5

// Calibration status word bit positions
`define ST_CAL_MODE   0
`define ST_CMD_ERR    1
`define ST_ARG_ERR    2
`define ST_KEY_ERR    4
`define ST_WIDTH      8

// Keyword and argument shapes
`define KEY_DIGITS    3'h5
`define KEY_BITS      20
`define TEMP_BITS     16
`define CHAN_MAX_BIG  10'h3E0
`define CHAN_MAX_SML  10'h2E8
`define CHAN_FIRST    10'h001

// Indicator flash half period, milliseconds
`define FLASH_HALF_MS 250
`define CLK_KHZ       10000

// Sequencer states
`define S_IDLE        2'h0
`define S_RDOLD       2'h1
`define S_MEAS        2'h2
`define S_WRITE       2'h3

`endif

// ### src/cj_offset_mem.v
// Cold-junction offset store, one word per sensor
`timescale 1ns/100ps
module cj_offset_mem #(
   parameter AW = 7,
   parameter DW = 16
) (
   input  wire          i_clk,     // System clock
   input  wire          i_we,      // Write strobe
   input  wire [AW-1:0] i_waddr,   // Write address
   input  wire [DW-1:0] i_wdata,   // Write data
   input  wire [AW-1:0] i_raddr_a, // Read address, sequencer
   input  wire [AW-1:0] i_raddr_b, // Read address, compensation
   output reg  [DW-1:0] o_rdata_a, // Registered read data a
   output reg  [DW-1:0] o_rdata_b  // Registered read data b
);

   reg [DW-1:0] mem [0:(1<<AW)-1];
   integer      n;

   // Power-up contents zero; block reset leaves the offsets alone
   initial
   begin
      for (n = 0; n < (1 << AW); n = n + 1)
      begin
         mem[n] = {DW{1'b0}};
      end
   end

   always @(posedge i_clk)
   begin
      if (i_we)
      begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata_a <= mem[i_raddr_a];
      o_rdata_b <= mem[i_raddr_b];
   end

endmodule

// ### src/calibration_mode_cmd_gate.v
// Calibration mode gate and cold-junction offset calibration sequencer
//
// Contract
// - Enter-calibration keyword must be exactly five decimal digits.
// - Calibration mode entered only on keyword match; else stays out.
// - Calibration commands outside calibration mode are rejected with error.
// - Non-calibration commands pass through in calibration mode too.
// - Keyword mismatch sets status bit of weight 16, read by status query.
// - A change-keyword command replaces the stored keyword.
// - Cold-junction channel must be 1..992 large model, 1..744 small.
// - Reference temperature is nnn.n degrees Celsius, four BCD digits.
// - Thermocouple type passes with the channel-configuration encoding.
// - Cold-junction calibration runs only in calibration mode.
// - Each channel maps to one sensor; compensation uses its offset.
// - Four sensors serve 32 channels per card; host calibrates four.
// - Computed correction stored internally as a sensor adjustment.
// - Trigger indicator flashes while calibration computes, stops after.
`timescale 1ns/100ps
`include "cal_gate_regs.vh"
module calibration_mode_cmd_gate #(
   parameter [`KEY_BITS-1:0] KEY_INIT     = 20'h0_0000,
   parameter                 FLASH_CYCLES = `FLASH_HALF_MS * `CLK_KHZ,
   parameter                 SENS_AW      = 7,
   parameter                 OFS_W        = 16
) (
   input  wire                  i_clk_sys,      // 10 MHz clock
   input  wire                  i_arst_n,       // Async reset, low
   input  wire                  i_model_large,  // 1: 992-channel model
   input  wire                  i_cmd_valid,    // Decoded command strobe
   output wire                  o_cmd_ready,    // Can take a command
   input  wire [2:0]            i_cmd_op,       // Command code
   input  wire [7:0]            i_cmd_code,     // Raw code of other cmd
   input  wire [2:0]            i_key_len,      // Keyword digit count
   input  wire [`KEY_BITS-1:0]  i_key_bcd,      // Keyword BCD digits
   input  wire [9:0]            i_cj_chan,      // Channel, binary
   input  wire [3:0]            i_cj_type,      // Thermocouple type
   input  wire [`TEMP_BITS-1:0] i_cj_temp_bcd,  // Temp nnn.n BCD
   output reg                   o_pass_valid,   // Forwarded cmd pulse
   output reg  [7:0]            o_pass_code,    // Forwarded cmd code
   output reg                   o_cmd_err,      // Rejected cmd pulse
   output reg                   o_status_valid, // Status answer pulse
   output reg  [`ST_WIDTH-1:0]  o_status_word,  // Status answer
   output wire                  o_cal_mode,     // Calibration mode
   output reg                   o_meas_req,     // Front-end read pulse
   output reg  [9:0]            o_meas_chan,    // Channel to read
   output reg  [3:0]            o_meas_type,    // Type to read with
   input  wire                  i_meas_valid,   // Reading ready pulse
   input  wire [OFS_W-1:0]      i_meas_tenths,  // Reading, 0.1 C signed
   input  wire [9:0]            i_comp_chan,    // Channel to compensate
   output wire [OFS_W-1:0]      o_comp_offset,  // Its sensor offset
   output reg                   o_cal_busy,     // Computation running
   output reg                   o_trig_led      // Trigger indicator
);

   // All digits of a BCD word must be 0..9
   function bcd_ok;
      input [`KEY_BITS-1:0] v;
      integer k;
      begin
         bcd_ok = 1'b1;
         for (k = 0; k < `KEY_BITS; k = k + 4)
         begin
            if (v[k+3 -: 4] > 4'h9)
            begin
               bcd_ok = 1'b0;
            end
         end
      end
   endfunction

   // Sensor index: card number and which quarter of its 32 channels
   function [6:0] sensor_of;
      input [9:0] chan;
      reg   [9:0] c;
      begin
         c = chan - `CHAN_FIRST;
         sensor_of = {c[9:5], c[4:3]};
      end
   endfunction

   reg       rst_s1_reg;
   reg       rst_s2_reg;
   wire      rst_n = rst_s2_reg;

   always @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end

   reg [`KEY_BITS-1:0] key_reg;
   reg                 cal_reg;
   reg                 key_err_reg;
   reg                 cmd_err_reg;
   reg                 arg_err_reg;
   reg [1:0]           state_reg;
   reg [SENS_AW-1:0]   sens_reg;
   reg [OFS_W-1:0]     ref_reg;
   reg [OFS_W-1:0]     wdata_reg;
   reg                 we_reg;
   reg [31:0]          flash_cnt_reg;

   wire [OFS_W-1:0] old_ofs;
   wire             take = i_cmd_valid && (state_reg == `S_IDLE);
   wire [9:0]       chan_max = i_model_large ? `CHAN_MAX_BIG : `CHAN_MAX_SML;

   // Five decimal digits
   wire key_form = (i_key_len == `KEY_DIGITS) && bcd_ok(i_key_bcd);
   // Channel in range
   wire chan_ok  = (i_cj_chan >= `CHAN_FIRST) && (i_cj_chan <= chan_max);
   // Reference temperature digits
   wire temp_ok  = bcd_ok({4'h0, i_cj_temp_bcd});
   wire cal_cmd  = (i_cmd_op == `OP_CJ_CAL) || (i_cmd_op == `OP_END_CAL);

   // nnn.n BCD to signed tenths
   wire [OFS_W-1:0] temp_bin =
      i_cj_temp_bcd[15:12] * 16'd1000 + i_cj_temp_bcd[11:8] * 16'd100 +
      i_cj_temp_bcd[7:4] * 16'd10 + {12'h000, i_cj_temp_bcd[3:0]};

   assign o_cmd_ready = (state_reg == `S_IDLE);
   assign o_cal_mode  = cal_reg;

   always @(posedge i_clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         key_reg        <= KEY_INIT;
         cal_reg        <= 1'b0;
         key_err_reg    <= 1'b0;
         cmd_err_reg    <= 1'b0;
         arg_err_reg    <= 1'b0;
         state_reg      <= `S_IDLE;
         sens_reg       <= {SENS_AW{1'b0}};
         ref_reg        <= {OFS_W{1'b0}};
         wdata_reg      <= {OFS_W{1'b0}};
         we_reg         <= 1'b0;
         o_pass_valid   <= 1'b0;
         o_pass_code    <= 8'h00;
         o_cmd_err      <= 1'b0;
         o_status_valid <= 1'b0;
         o_status_word  <= {`ST_WIDTH{1'b0}};
         o_meas_req     <= 1'b0;
         o_meas_chan    <= 10'h000;
         o_meas_type    <= 4'h0;
         o_cal_busy     <= 1'b0;
      end
      else
      begin
         o_pass_valid   <= 1'b0;
         o_cmd_err      <= 1'b0;
         o_status_valid <= 1'b0;
         o_meas_req     <= 1'b0;
         we_reg         <= 1'b0;
         case (state_reg)
            `S_IDLE:
            begin
               if (take)
               begin
                  // Query reports, then clears, the command and argument reject flags
                  if (i_cmd_op == `OP_STAT_QRY)
                  begin
                     o_status_valid <= 1'b1;
                     o_status_word  <= {`ST_WIDTH{1'b0}};
                     o_status_word[`ST_CAL_MODE] <= cal_reg;
                     o_status_word[`ST_CMD_ERR]  <= cmd_err_reg;
                     o_status_word[`ST_ARG_ERR]  <= arg_err_reg;
                     o_status_word[`ST_KEY_ERR]  <= key_err_reg;
                     cmd_err_reg <= 1'b0;
                     arg_err_reg <= 1'b0;
                  end
                  else if (i_cmd_op == `OP_ENTER_CAL && !key_form)
                  begin
                     o_cmd_err   <= 1'b1;
                     arg_err_reg <= 1'b1;
                  end
                  else if (i_cmd_op == `OP_ENTER_CAL)
                  begin
                     cal_reg     <= (i_key_bcd == key_reg);
                     key_err_reg <= (i_key_bcd != key_reg);
                     o_cmd_err   <= (i_key_bcd != key_reg);
                  end
                  else if (i_cmd_op == `OP_CHG_KEY)
                  begin
                     if (key_form)
                     begin
                        key_reg <= i_key_bcd;
                     end
                     else
                     begin
                        o_cmd_err   <= 1'b1;
                        arg_err_reg <= 1'b1;
                     end
                  end
                  else if (cal_cmd && !cal_reg)
                  begin
                     o_cmd_err   <= 1'b1;
                     cmd_err_reg <= 1'b1;
                  end
                  else if (i_cmd_op == `OP_END_CAL)
                  begin
                     cal_reg <= 1'b0;
                  end
                  // calibration only in mode; argument checks
                  else if (i_cmd_op == `OP_CJ_CAL)
                  begin
                     if (chan_ok && temp_ok)
                     begin
                        sens_reg    <= sensor_of(i_cj_chan);
                        ref_reg     <= temp_bin;
                        o_meas_chan <= i_cj_chan;
                        o_meas_type <= i_cj_type;
                        o_cal_busy  <= 1'b1;
                        state_reg   <= `S_RDOLD;
                     end
                     else
                     begin
                        o_cmd_err   <= 1'b1;
                        arg_err_reg <= 1'b1;
                     end
                  end
                  // other commands pass in any mode
                  else
                  begin
                     o_pass_valid <= 1'b1;
                     o_pass_code  <= i_cmd_code;
                  end
               end
            end
            `S_RDOLD:
            begin
               o_meas_req <= 1'b1;
               state_reg  <= `S_MEAS;
            end
            `S_MEAS:
            begin
               if (i_meas_valid)
               begin
                  wdata_reg <= old_ofs + ref_reg - i_meas_tenths;
                  we_reg    <= 1'b1;
                  state_reg <= `S_WRITE;
               end
            end
            `S_WRITE:
            begin
               o_cal_busy <= 1'b0;
               state_reg  <= `S_IDLE;
            end
            default:
            begin
               state_reg <= `S_IDLE;
            end
         endcase
      end
   end

   always @(posedge i_clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flash_cnt_reg <= 32'h0000_0000;
         o_trig_led    <= 1'b0;
      end
      // Cleared with busy so it never outlives the computation
      else if (!o_cal_busy || state_reg == `S_WRITE)
      begin
         flash_cnt_reg <= 32'h0000_0000;
         o_trig_led    <= 1'b0;
      end
      else if (flash_cnt_reg >= FLASH_CYCLES - 1)
      begin
         flash_cnt_reg <= 32'h0000_0000;
         o_trig_led    <= ~o_trig_led;
      end
      else
      begin
         flash_cnt_reg <= flash_cnt_reg + 32'h0000_0001;
      end
   end

   // compensation reads the channel's own sensor offset
   cj_offset_mem #(
      .AW (SENS_AW),
      .DW (OFS_W)
   ) u_mem (
      .i_clk     (i_clk_sys),
      .i_we      (we_reg),
      .i_waddr   (sens_reg),
      .i_wdata   (wdata_reg),
      .i_raddr_a (sens_reg),
      .i_raddr_b (sensor_of(i_comp_chan)),
      .o_rdata_a (old_ofs),
      .o_rdata_b (o_comp_offset)
   );

endmodule

// ### tb/front_end_model.sv
// Front-end model answering offset reading requests
`timescale 1ns/100ps
module front_end_model (
   input  wire        i_clk,    // System clock
   input  wire        i_req,    // Reading request pulse
   input  wire [7:0]  i_lat,    // Answer latency, cycles
   input  wire [15:0] i_val,    // Reading to return
   output reg         o_valid,  // Reading ready pulse
   output reg  [15:0] o_tenths  // Reading, 0.1 C
);
   initial
   begin
      o_valid = 1'b0;
      o_tenths = 16'h5a5a;
   end

   // Busy answering, so a second request here would be lost
   always @(posedge i_clk)
      if (i_req)
      begin
         repeat (i_lat) @(posedge i_clk);
         o_valid <= 1'b1;
         o_tenths <= i_val;
         @(posedge i_clk);
         o_valid <= 1'b0;
         // Stale reading must not look valid
         o_tenths <= ~i_val;
      end
endmodule

// ### tb/calibration_mode_cmd_gate_assertions.sv
// Assertion checker for the calibration mode command gate
`timescale 1ns/100ps
`include "cal_gate_regs.vh"
module cal_gate_chk (
   input wire       i_clk_sys,     // Clock
   input wire       i_arst_n,      // Reset, low
   input wire       i_cmd_valid,   // Strobe
   input wire       o_cmd_ready,   // Ready
   input wire [2:0] i_cmd_op,      // Op
   input wire [7:0] i_cmd_code,    // Raw code
   input wire [2:0] i_key_len,     // Digits
   input wire       o_pass_valid,  // Forwarded
   input wire [7:0] o_pass_code,   // Fwd code
   input wire       o_cmd_err,     // Rejected
   input wire       o_cal_mode,    // Mode
   input wire       o_meas_req,    // Read req
   input wire       i_meas_valid,  // Reading
   input wire       o_cal_busy,    // Busy
   input wire       o_trig_led     // Indicator
);
   wire take = i_cmd_valid && o_cmd_ready;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_arst_n);

   AST_FWD: assert property (
      take && i_cmd_op == `OP_OTHER |=> o_pass_valid
      && o_pass_code == $past(i_cmd_code)) else $error("not forwarded");
   AST_KEY_LEN: assert property (
      take && i_cmd_op == `OP_ENTER_CAL && i_key_len != `KEY_DIGITS
      |=> o_cmd_err && !o_pass_valid) else $error("short key taken");
   AST_ENTER_ONLY: assert property (
      !o_cal_mode && !(take && i_cmd_op == `OP_ENTER_CAL)
      |=> !o_cal_mode) else $error("mode entered without key");
   AST_CAL_REJ: assert property (
      take && i_cmd_op == `OP_CJ_CAL && !o_cal_mode
      |=> o_cmd_err && !o_cal_busy) else $error("cal out of mode");
   AST_HOLD: assert property (
      o_cal_mode && !(take && (i_cmd_op == `OP_END_CAL
      || i_cmd_op == `OP_ENTER_CAL)) |=> o_cal_mode)
      else $error("mode dropped");
   AST_REQ: assert property (
      $rose(o_cal_busy) |=> o_meas_req) else $error("no reading request");
   AST_DONE: assert property (
      i_meas_valid && o_cal_busy |=> o_cal_busy ##1 !o_cal_busy)
      else $error("busy end wrong");
   AST_LED: assert property (
      !o_cal_busy |-> !o_trig_led) else $error("indicator when idle");

   cover property (take && i_cmd_op == `OP_CJ_CAL && o_cal_mode);
   cover property ($rose(o_cal_mode));
   cover property ($rose(o_trig_led));
endmodule

bind calibration_mode_cmd_gate cal_gate_chk u_chk (.i_clk_sys, .i_arst_n,
   .i_cmd_valid, .o_cmd_ready, .i_cmd_op, .i_cmd_code, .i_key_len,
   .o_pass_valid, .o_pass_code, .o_cmd_err, .o_cal_mode, .o_meas_req,
   .i_meas_valid, .o_cal_busy, .o_trig_led);

// ### tb/tb_calibration_mode_cmd_gate.sv
// Self-checking bench for the calibration mode command gate
`timescale 1ns/100ps
`include "cal_gate_regs.vh"
module tb_calibration_mode_cmd_gate;
   reg         i_clk_sys = 1'b0, i_arst_n = 1'b0, i_cmd_valid = 1'b0;
   reg         i_model_large = 1'b1;
   reg  [2:0]  i_cmd_op = 3'h0, i_key_len = 3'h0;
   reg  [7:0]  i_cmd_code = 8'h00, lat = 8'h02;
   reg  [19:0] i_key_bcd = 20'h0_0000;
   reg  [9:0]  i_cj_chan = 10'h001, i_comp_chan = 10'h001;
   reg  [3:0]  i_cj_type = 4'h0;
   reg  [15:0] i_cj_temp_bcd = 16'h0000, rd = 16'h0123;
   wire        o_cmd_ready, o_pass_valid, o_cmd_err, o_status_valid;
   wire        o_cal_mode, o_meas_req, i_meas_valid, o_cal_busy, o_trig_led;
   wire [7:0]  o_pass_code, o_status_word;
   wire [9:0]  o_meas_chan;
   wire [3:0]  o_meas_type;
   wire [15:0] i_meas_tenths, o_comp_offset;
   integer     error_cnt = 0, n_tests = 0, cyc = 0, seed = 39;
   integer     mode = 0, st = 0, key = 0, lg = 1, i;
   int         chs[5] = '{0, 992, 993, 744, 745};
   integer     ofs[0:127];

   calibration_mode_cmd_gate #(.FLASH_CYCLES(4)) dut_u (.i_clk_sys,
      .i_arst_n, .i_model_large, .i_cmd_valid, .o_cmd_ready, .i_cmd_op,
      .i_cmd_code, .i_key_len, .i_key_bcd, .i_cj_chan, .i_cj_type,
      .i_cj_temp_bcd, .o_pass_valid, .o_pass_code, .o_cmd_err,
      .o_status_valid, .o_status_word, .o_cal_mode, .o_meas_req,
      .o_meas_chan, .o_meas_type, .i_meas_valid, .i_meas_tenths,
      .i_comp_chan, .o_comp_offset, .o_cal_busy, .o_trig_led);
   front_end_model fe_u (.i_clk(i_clk_sys), .i_req(o_meas_req),
      .i_lat(lat), .i_val(rd), .o_valid(i_meas_valid),
      .o_tenths(i_meas_tenths));

   always #50 i_clk_sys = ~i_clk_sys;

   task wrap_up;
   begin
      if (error_cnt == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask

   // Whole run is near 150 cycles
   always @(posedge i_clk_sys)
   begin
      cyc = cyc + 1;
      if (cyc == 5000)
      begin
         error_cnt = error_cnt + 1;
         wrap_up;
      end
   end

   task chk(input [31:0] got, input [31:0] exp);
   begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask

   function integer ok_bcd(input [19:0] v);
      integer j;
   begin
      ok_bcd = 1;
      for (j = 0; j < 5; j = j + 1)
         if (v[4*j +: 4] > 9)
            ok_bcd = 0;
   end
   endfunction

   task cmd(input integer op, len, k, ch, t);
      integer b, c, w, n, tg, s;
      reg     led;
   begin
      b = 0;
      c = 0;
      w = mode | st;
      case (op)
         `OP_ENTER_CAL, `OP_CHG_KEY:
            if (len != 5 || !ok_bcd(k[19:0]))
               b = 4;
            else if (op == `OP_CHG_KEY)
               key = k;
            else
            begin
               mode = (k == key);
               b = mode ? 0 : 16;
               st = st & 'hF;
            end
         `OP_END_CAL:
            if (mode)
               mode = 0;
            else
               b = 2;
         `OP_CJ_CAL:
            if (!mode)
               b = 2;
            else if (ch == 0 || ch > (lg ? 992 : 744) || !ok_bcd(t[15:0]))
               b = 4;
            else
               c = 1;
         `OP_STAT_QRY:
            st = st & 16;
      endcase
      st = st | b;
      @(posedge i_clk_sys);
      i_cmd_valid <= 1'b1;
      i_cmd_op <= op[2:0];
      i_cmd_code <= $random(seed);
      i_key_len <= len[2:0];
      i_key_bcd <= k[19:0];
      i_cj_chan <= ch[9:0];
      i_cj_type <= $random(seed);
      i_cj_temp_bcd <= t[15:0];
      i_model_large <= lg[0];
      i_comp_chan <= ch[9:0];
      @(posedge i_clk_sys);
      i_cmd_valid <= 1'b0;
      @(negedge i_clk_sys);
      chk(o_cmd_err, b != 0);
      chk(o_pass_valid, op == `OP_OTHER);
      if (op == `OP_OTHER)
         chk(o_pass_code, i_cmd_code);
      chk(o_status_valid, op == `OP_STAT_QRY);
      if (op == `OP_STAT_QRY)
         chk(o_status_word, w);
      chk(o_cal_mode, mode);
      chk(o_cal_busy, c);
      if (c)
      begin
         chk(o_meas_chan, ch);
         chk(o_meas_type, i_cj_type);
         chk(o_cmd_ready, 0);
         tg = 0;
         led = o_trig_led;
         for (n = 0; n < 400 && o_cal_busy === 1'b1; n = n + 1)
         begin
            @(negedge i_clk_sys);
            tg = tg + (o_trig_led !== led);
            led = o_trig_led;
         end
         chk(o_cal_busy, 0);
         chk(tg > 2, lat > 12);
         chk(o_trig_led, 0);
         s = (ch - 1) / 8;
         ofs[s] = (ofs[s] + 1000 * t[15:12] + 100 * t[11:8]
            + 10 * t[7:4] + t[3:0] - rd) & 'hFFFF;
         @(negedge i_clk_sys);
         chk(o_comp_offset, ofs[s]);
      end
   end
   endtask

   initial
   begin
      for (i = 0; i < 128; i = i + 1)
         ofs[i] = 0;
      repeat (4) @(posedge i_clk_sys);
      i_arst_n <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      cmd(`OP_OTHER, 5, 0, 1, 0);
      cmd(`OP_END_CAL, 5, 0, 1, 0);
      cmd(`OP_CJ_CAL, 5, 0, 1, 'h1017);
      cmd(`OP_STAT_QRY, 5, 0, 1, 0);
      cmd(`OP_ENTER_CAL, 4, 0, 1, 0);
      cmd(`OP_ENTER_CAL, 5, 'h0000A, 1, 0);
      cmd(`OP_ENTER_CAL, 5, 'h12345, 1, 0);
      cmd(`OP_STAT_QRY, 5, 0, 1, 0);
      cmd(`OP_CHG_KEY, 5, 'h12345, 1, 0);
      cmd(`OP_ENTER_CAL, 5, 'h12345, 1, 0);
      cmd(`OP_STAT_QRY, 5, 0, 1, 0);
      cmd(`OP_OTHER, 5, 0, 1, 0);
      for (i = 0; i < 5; i = i + 1)
      begin
         lg = (i < 3);
         lat = (i == 1) ? 8'h14 : 8'h02;
         cmd(`OP_CJ_CAL, 5, 0, chs[i], 'h1017);
      end
      cmd(`OP_CJ_CAL, 5, 0, 8, 'h10A0);
      for (i = 0; i < 4; i = i + 1)
      begin
         rd = $random(seed);
         lat = i[0] ? 8'h14 : 8'h02;
         cmd(`OP_CJ_CAL, 5, 0, 1 + 8 * i + {$random(seed)} % 8,
             $random(seed) & 'h7777);
      end
      cmd(`OP_END_CAL, 5, 0, 1, 0);
      cmd(`OP_CJ_CAL, 5, 0, 1, 'h1017);
      cmd(`OP_STAT_QRY, 5, 0, 1, 0);
      wrap_up;
   end
endmodule
